// ===== dla_adapter.v
`include "dla_defines.vh"

module dla_adapter (
  input wire sys_clk,
  input wire reset_n,
  // Link layer to adapter.
  input wire linklayer_tx_ready,
  input wire linklayer_tx_valid,
  input wire [`DLA_DATA_W-1:0] linklayer_tx_bytes,
  input wire [`DLA_STREAM_W-1:0] linklayer_tx_stream_id,
  input wire linklayer_halt_acknowledge,
  input wire [3:0] linklayer_state_request,
  input wire linklayer_unused_tied_input,
  // Adapter to link layer.
  output reg adapter_tx_ready,
  output reg adapter_rx_valid,
  output reg [`DLA_DATA_W-1:0] adapter_rx_bytes,
  output reg [`DLA_STREAM_W-1:0] adapter_rx_stream_id,
  output reg adapter_recoverable_err,
  output reg adapter_fatal_err,
  output reg adapter_correctable_err,
  output reg adapter_halt_request,
  output reg adapter_time_mark,
  output reg [7:0] adapter_time_mark_stream_id,
  output reg adapter_in_low_power_one,
  output reg adapter_in_low_power_two,
  output reg [3:0] adapter_state_report,
  output reg [2:0] adapter_width_report,
  output reg adapter_sudden_drop,
  output reg [2:0] adapter_rate_code,
  output reg [2:0] adapter_protocol_code,
  // Adapter to PHY, same clock.
  output reg phy_tx_valid,
  output reg [`DLA_DATA_W-1:0] phy_tx_bytes,
  output reg [`DLA_STREAM_W-1:0] phy_tx_stream_id,
  input wire phy_tx_ready,
  input wire phy_rx_valid,
  input wire [`DLA_DATA_W-1:0] phy_rx_bytes,
  input wire [`DLA_STREAM_W-1:0] phy_rx_stream_id,
  input wire phy_link_ready,
  input wire phy_fatal_err
);
  localparam FW = `DLA_DATA_W + `DLA_STREAM_W;

  // Controller states, binary coded.
  localparam S_RESET = 3'h0;
  localparam S_ACTIVE = 3'h1;
  localparam S_HALT = 3'h2;
  localparam S_L1 = 3'h3;
  localparam S_L2 = 3'h4;
  localparam S_LINKRESET = 3'h5;
  localparam S_ERROR = 3'h6;

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [3:0] target_ff;
  reg [3:0] nxt_target;
  reg halt_req_ff;
  reg nxt_halt_req;
  reg fatal_ff;
  reg ack_low_ff;

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [FW-1:0] fifo_out_data;
  wire [`DLA_FIFO_LVL_W-1:0] fifo_level;
  wire tx_take;
  wire overrun;
  wire req_valid;

  // Unused input is tied off by the link layer and ignored here.

  // Maps an internal state to the reported code.
  function [3:0] state_code;
    input [2:0] st;
    begin
      case (st)
        S_ACTIVE: state_code = `DLA_ST_ACTIVE;
        S_HALT: state_code = `DLA_ST_ACTIVE;
        S_L1: state_code = `DLA_ST_L1;
        S_L2: state_code = `DLA_ST_L2;
        S_LINKRESET: state_code = `DLA_ST_LINKRESET;
        S_ERROR: state_code = `DLA_ST_LINKERROR;
        default: state_code = `DLA_ST_RESET;
      endcase
    end
  endfunction

  // True for request codes this adapter can honour.
  function supported_req;
    input [3:0] code;
    begin
      case (code)
        `DLA_ST_ACTIVE: supported_req = 1'b1;
        `DLA_ST_L1: supported_req = 1'b1;
        `DLA_ST_L2: supported_req = 1'b1;
        `DLA_ST_LINKRESET: supported_req = 1'b1;
        default: supported_req = 1'b0;
      endcase
    end
  endfunction

  assign req_valid = supported_req(linklayer_state_request);

  // A beat moves only with valid, link ready and our registered ready.
  assign tx_take = linklayer_tx_valid & linklayer_tx_ready &
                   adapter_tx_ready;
  // Cannot happen with the headroom kept below, but would lose data.
  assign overrun = tx_take & ~fifo_in_ready;

  // The FIFO absorbs a slower PHY; its fill level throttles the link.
  dla_fifo #(
    .WIDTH(FW),
    .DEPTH(`DLA_FIFO_DEPTH),
    .AW(`DLA_FIFO_AW),
    .LW(`DLA_FIFO_LVL_W)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(tx_take),
    .in_ready(fifo_in_ready),
    .in_data({linklayer_tx_stream_id, linklayer_tx_bytes}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Output stage register empties into the PHY when it is ready.
  assign fifo_out_ready = ~phy_tx_valid | phy_tx_ready;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phy_tx_valid <= 1'b0;
      phy_tx_bytes <= `DLA_RST_BYTES;
      phy_tx_stream_id <= `DLA_RST_STREAM;
    end else if (fifo_out_ready) begin
      phy_tx_valid <= fifo_out_valid;
      phy_tx_bytes <= fifo_out_data[`DLA_DATA_W-1:0];
      phy_tx_stream_id <= fifo_out_data[FW-1:`DLA_DATA_W];
    end
  end

  // Virtual link state machine.
  always @* begin
    nxt_state = state_ff;
    nxt_target = target_ff;
    nxt_halt_req = halt_req_ff;
    case (state_ff)
      S_RESET: begin
        if (linklayer_state_request == `DLA_ST_ACTIVE && phy_link_ready) begin
          nxt_state = S_ACTIVE;
        end
      end
      S_ACTIVE: begin
        if (req_valid && linklayer_state_request != `DLA_ST_ACTIVE) begin
          // Leaving active needs the link layer to stop sending first.
          nxt_target = linklayer_state_request;
          nxt_halt_req = 1'b1;
          nxt_state = S_HALT;
        end
      end
      S_HALT: begin
        // Wait for the acknowledge and for queued beats to leave.
        if (linklayer_halt_acknowledge && ack_low_ff && !fifo_out_valid &&
            !phy_tx_valid) begin
          nxt_halt_req = 1'b0;
          case (target_ff)
            `DLA_ST_L1: nxt_state = S_L1;
            `DLA_ST_L2: nxt_state = S_L2;
            default: nxt_state = S_LINKRESET;
          endcase
        end
      end
      S_L1: begin
        if (linklayer_state_request == `DLA_ST_ACTIVE && phy_link_ready) begin
          nxt_state = S_ACTIVE;
        end else if (linklayer_state_request == `DLA_ST_LINKRESET) begin
          nxt_state = S_LINKRESET;
        end
      end
      S_L2: begin
        // Waking from the deepest state goes back through reset.
        if (linklayer_state_request == `DLA_ST_ACTIVE) begin
          nxt_state = S_RESET;
        end
      end
      S_LINKRESET: begin
        if (linklayer_state_request != `DLA_ST_LINKRESET) begin
          nxt_state = S_RESET;
        end
      end
      S_ERROR: begin
        nxt_state = S_ERROR;
      end
      default: begin
        nxt_state = S_RESET;
      end
    endcase
    // No recovery exists, so any fatal condition is terminal.
    if (phy_fatal_err || overrun) begin
      nxt_state = S_ERROR;
      nxt_halt_req = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_RESET;
      target_ff <= `DLA_ST_RESET;
      halt_req_ff <= 1'b0;
      fatal_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      target_ff <= nxt_target;
      halt_req_ff <= nxt_halt_req;
      // Sticky until reset; nothing clears a fatal error.
      if (phy_fatal_err || overrun) begin
        fatal_ff <= 1'b1;
      end
    end
  end

  // A late acknowledge of the previous halt must not end a new one, so
  // only an acknowledge that follows a low level counts.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_low_ff <= 1'b0;
    end else if (!halt_req_ff) begin
      ack_low_ff <= 1'b0;
    end else if (!linklayer_halt_acknowledge) begin
      ack_low_ff <= 1'b1;
    end
  end

  // Registered outputs toward the link layer.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adapter_tx_ready <= 1'b0;
      adapter_rx_valid <= 1'b0;
      adapter_rx_bytes <= `DLA_RST_BYTES;
      adapter_rx_stream_id <= `DLA_RST_STREAM;
      adapter_fatal_err <= 1'b0;
      adapter_halt_request <= 1'b0;
      adapter_in_low_power_one <= 1'b0;
      adapter_in_low_power_two <= 1'b0;
      adapter_state_report <= `DLA_ST_RESET;
    end else begin
      // Two words of headroom cover the beat already in flight.
      adapter_tx_ready <= (nxt_state == S_ACTIVE) &&
        (fifo_level < (`DLA_FIFO_DEPTH - `DLA_FIFO_HEADROOM));
      adapter_rx_valid <= phy_rx_valid &&
        (state_ff == S_ACTIVE || state_ff == S_HALT);
      if (phy_rx_valid) begin
        adapter_rx_bytes <= phy_rx_bytes;
        adapter_rx_stream_id <= phy_rx_stream_id;
      end
      adapter_fatal_err <= fatal_ff | phy_fatal_err | overrun;
      adapter_halt_request <= nxt_halt_req;
      adapter_in_low_power_one <= (nxt_state == S_L1);
      adapter_in_low_power_two <= (nxt_state == S_L2);
      adapter_state_report <= state_code(nxt_state);
    end
  end

  // Fixed and tied outputs, still driven from flip-flops.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adapter_recoverable_err <= 1'b0;
      adapter_correctable_err <= 1'b0;
      adapter_time_mark <= 1'b0;
      adapter_time_mark_stream_id <= `DLA_RST_STREAM;
      adapter_sudden_drop <= 1'b0;
      adapter_width_report <= `DLA_WIDTH_X16;
      adapter_rate_code <= `DLA_RATE_GEN5;
      adapter_protocol_code <= `DLA_PROTO_CODE;
    end else begin
      adapter_recoverable_err <= 1'b0;
      adapter_correctable_err <= 1'b0;
      // Timing logic uses a fixed adapter delay instead of stamps.
      adapter_time_mark <= 1'b0;
      adapter_time_mark_stream_id <= `DLA_RST_STREAM;
      adapter_sudden_drop <= 1'b0;
      adapter_width_report <= `DLA_WIDTH_X16;
      adapter_rate_code <= `DLA_RATE_GEN5;
      adapter_protocol_code <= `DLA_PROTO_CODE;
    end
  end
endmodule // dla_adapter

// ===== dla_adapter_properties.sv
module dla_adapter_properties (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic phy_fatal_err,
  input wire logic phy_rx_valid,
  input wire logic [63:0] phy_rx_bytes,
  input wire logic adapter_tx_ready,
  input wire logic adapter_rx_valid,
  input wire logic [63:0] adapter_rx_bytes,
  input wire logic adapter_recoverable_err,
  input wire logic adapter_correctable_err,
  input wire logic adapter_fatal_err,
  input wire logic adapter_halt_request,
  input wire logic adapter_in_low_power_one,
  input wire logic adapter_in_low_power_two,
  input wire logic adapter_time_mark,
  input wire logic [7:0] adapter_time_mark_stream_id,
  input wire logic adapter_sudden_drop,
  input wire logic [3:0] adapter_state_report,
  input wire logic [2:0] adapter_width_report,
  input wire logic [2:0] adapter_rate_code,
  input wire logic [2:0] adapter_protocol_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  recov_zero_a: assert property (!adapter_recoverable_err)
    else $error("recoverable error raised");
  corr_zero_a: assert property (!adapter_correctable_err)
    else $error("correctable error raised");
  time_mark_a: assert property (!adapter_time_mark &&
    adapter_time_mark_stream_id == 8'h00) else $error("time mark not zero");
  sudden_drop_a: assert property (!adapter_sudden_drop)
    else $error("sudden drop raised");
  width_code_a: assert property (adapter_width_report == 3'h4)
    else $error("width code wrong");
  rate_proto_a: assert property (adapter_rate_code == 3'h4 &&
    adapter_protocol_code == 3'h2) else $error("rate or protocol wrong");
  fatal_sticky_a: assert property (phy_fatal_err |=>
    (adapter_fatal_err && adapter_state_report == 4'hA) [*3])
    else $error("fatal error not reported");
  rx_pass_a: assert property (phy_rx_valid && !phy_fatal_err &&
    adapter_state_report == 4'h1 |=> adapter_rx_valid &&
    adapter_rx_bytes == $past(phy_rx_bytes)) else $error("rx beat lost");
  stall_idle_a: assert property (adapter_state_report != 4'h1 |->
    !adapter_tx_ready) else $error("ready outside active");
  halt_stall_a: assert property (adapter_halt_request |->
    !adapter_tx_ready && adapter_state_report == 4'h1)
    else $error("ready during halt");
  low_power_a: assert property (adapter_in_low_power_one ==
    (adapter_state_report == 4'h4) && adapter_in_low_power_two ==
    (adapter_state_report == 4'h8)) else $error("low power flag wrong");
endmodule // dla_adapter_properties

// ===== dla_defines.vh
`ifndef DLA_DEFINES_VH
`define DLA_DEFINES_VH
// Contract
// - All port signals run on the interface clock.
// - Adapter outputs go up, link outputs come down.
// - One port only; single-bit valid both ways.
// - Always report the sixteen-lane width code.
// - Drop tx ready to stall the link layer.
// - Recoverable error output held at zero.
// - Fatal link errors shown on training error.
// - Time mark and its stream id held zero.
// - Only supported state codes requested and reported.
// - Each signal tied, passed, fixed or handshaken.
// - Sudden link drop output held at zero.
// - Rate code fixed at fifth generation.
// - Protocol code fixed to coherent-link protocol.

// Datapath sizes.
`define DLA_NBYTES 8
`define DLA_DATA_W 64
`define DLA_STREAM_W 8
`define DLA_FIFO_DEPTH 32
`define DLA_FIFO_AW 5
`define DLA_FIFO_LVL_W 6
// Ready drops once no more than this many words are free.
`define DLA_FIFO_HEADROOM 6'h02

// Fixed configuration codes.
`define DLA_WIDTH_X16 3'h4
`define DLA_RATE_GEN5 3'h4
`define DLA_PROTO_CODE 3'h2

// Link state codes, shared by request and report.
`define DLA_ST_RESET 4'h0
`define DLA_ST_ACTIVE 4'h1
`define DLA_ST_L1 4'h4
`define DLA_ST_L2 4'h8
`define DLA_ST_LINKRESET 4'h9
`define DLA_ST_LINKERROR 4'hA

// Reset values of the stream outputs.
`define DLA_RST_BYTES 64'h0000000000000000
`define DLA_RST_STREAM 8'h00
`endif

// ===== dla_fifo.v
module dla_fifo #(
  parameter WIDTH = 72,
  parameter DEPTH = 32,
  parameter AW = 5,
  parameter LW = 6
) (
  input wire sys_clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [LW-1:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [LW-1:0] count_ff;
  wire do_wr;
  wire do_rd;

  assign in_ready = (count_ff != DEPTH[LW-1:0]);
  assign out_valid = (count_ff != {LW{1'b0}});
  assign out_data = mem[rd_ptr_ff];
  assign level = count_ff;
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // Storage has no reset so it can map onto plain memory.
  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {LW{1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + {{(LW-1){1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - {{(LW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dla_fifo

// ===== dla_link_model.sv
module dla_link_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic adapter_halt_request,
  output logic linklayer_halt_acknowledge
);
  logic [3:0] wait_ff;
  // The acknowledge stands until the request falls; a slow answer makes
  // the adapter hold its halt state for several cycles.
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_ff <= 4'h0;
      linklayer_halt_acknowledge <= 1'b0;
    end else if (adapter_halt_request) begin
      wait_ff <= wait_ff + {3'h0, wait_ff != 4'hF};
      linklayer_halt_acknowledge <= !slow || wait_ff >= 4'h7;
    end else begin
      wait_ff <= 4'h0;
      linklayer_halt_acknowledge <= 1'b0;
    end
  end
endmodule // dla_link_model

// ===== tb_dla_adapter.sv
module tb_dla_adapter;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, reset_n = 1'b0, slow = 1'b0, ack;
  logic ll_rdy = 1'b0, ll_vld = 1'b0, ptx_rdy = 1'b0, prx_vld = 1'b0;
  logic plink = 1'b0, pfat = 1'b0, tx_rdy, rx_vld, fatal, lp1, lp2, hreq;
  logic ptx_vld, rx_pend = 1'b0;
  logic [63:0] ll_bytes = 64'h0, prx_bytes = 64'h0, rx_bytes, ptx_bytes;
  logic [7:0] ll_sid = 8'h00, prx_sid = 8'h00, rx_sid, ptx_sid;
  logic [3:0] ll_req = 4'h0, report;
  logic [2:0] wid, rate, proto;
  logic [71:0] txq[$], rx_exp, exp;
  int miscompares = 0, samples_checked = 0, cycles = 0, acc = 0;
  always #5 sys_clk = ~sys_clk;
  dla_adapter u_dla_adapter (.sys_clk, .reset_n, .linklayer_tx_ready(ll_rdy),
    .linklayer_tx_valid(ll_vld), .linklayer_tx_bytes(ll_bytes),
    .linklayer_tx_stream_id(ll_sid), .linklayer_halt_acknowledge(ack),
    .linklayer_state_request(ll_req), .linklayer_unused_tied_input(1'b0),
    .adapter_tx_ready(tx_rdy), .adapter_rx_valid(rx_vld),
    .adapter_rx_bytes(rx_bytes), .adapter_rx_stream_id(rx_sid),
    .adapter_recoverable_err(), .adapter_fatal_err(fatal),
    .adapter_correctable_err(), .adapter_halt_request(hreq),
    .adapter_time_mark(), .adapter_time_mark_stream_id(),
    .adapter_in_low_power_one(lp1), .adapter_in_low_power_two(lp2),
    .adapter_state_report(report), .adapter_width_report(wid),
    .adapter_sudden_drop(), .adapter_rate_code(rate),
    .adapter_protocol_code(proto), .phy_tx_valid(ptx_vld),
    .phy_tx_bytes(ptx_bytes), .phy_tx_stream_id(ptx_sid),
    .phy_tx_ready(ptx_rdy), .phy_rx_valid(prx_vld), .phy_rx_bytes(prx_bytes),
    .phy_rx_stream_id(prx_sid), .phy_link_ready(plink),
    .phy_fatal_err(pfat));
  dla_link_model u_dla_link_model (.sys_clk, .reset_n, .slow,
    .adapter_halt_request(hreq), .linklayer_halt_acknowledge(ack));
  task automatic chk(input string what, input logic [71:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_rep(input logic [3:0] c);
    for (int i = 0; i < 200 && report !== c; i++) @(posedge sys_clk);
    chk("state", c, report);
  endtask
  // One beat step; a beat not yet taken keeps its data and valid.
  task automatic step(input logic send);
    @(posedge sys_clk);
    if (!ll_vld || tx_rdy) begin
      ll_vld <= send & $urandom;
      ll_bytes <= {$urandom, $urandom};
      ll_sid <= $urandom;
    end
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  always @(posedge sys_clk) begin
    if (ll_vld && ll_rdy && tx_rdy) begin
      txq.push_back({ll_sid, ll_bytes});
      acc++;
    end
    if (ptx_vld && ptx_rdy) begin
      exp = (txq.size() != 0) ? txq.pop_front() : '1;
      chk("phy_tx", exp, {ptx_sid, ptx_bytes});
    end
    if (rx_pend) chk("rx_beat", rx_exp, {rx_sid, rx_bytes});
    if (rx_pend || rx_vld) chk("rx_valid", rx_pend, rx_vld);
    rx_pend <= prx_vld && report == 4'h1;
    rx_exp <= {prx_sid, prx_bytes};
  end
  initial begin
    void'($urandom(98));
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("codes", {3'h4, 3'h4, 3'h2, 4'h0},
        {wid, rate, proto, report});
    plink <= 1'b1;
    ll_req <= 4'h1;
    ll_rdy <= 1'b1;
    wait_rep(4'h1);
    repeat (300) begin
      step(1'b1);
      ptx_rdy <= $urandom;
      prx_vld <= $urandom;
      prx_bytes <= {$urandom, $urandom};
      prx_sid <= $urandom;
    end
    // Empty the path first so the fill count starts from nothing.
    repeat (60) begin
      step(1'b0);
      ptx_rdy <= 1'b1;
      prx_vld <= 1'b0;
    end
    chk("emptied", 1'b0, txq.size() != 0);
    acc = 0;
    // The output register holds one beat beyond the buffer itself.
    repeat (150) begin
      step(1'b1);
      ptx_rdy <= 1'b0;
    end
    chk("fill", 2'h3, {acc >= 30, acc <= 33});
    chk("stall", 1'b0, tx_rdy);
    repeat (150) begin
      step(1'b0);
      ptx_rdy <= $urandom;
    end
    chk("drained", 1'b0, txq.size() != 0);
    slow <= 1'b1;
    ll_req <= 4'h4;
    wait_rep(4'h4);
    chk("low_power", 3'h4, {lp1, tx_rdy, hreq});
    ll_req <= 4'h1;
    wait_rep(4'h1);
    ll_req <= 4'h3;
    repeat (4) @(posedge sys_clk);
    chk("ignored", 5'h03, {report, tx_rdy});
    slow <= 1'b0;
    ll_req <= 4'h8;
    wait_rep(4'h8);
    chk("low_power_two", 2'h1, {lp1, lp2});
    ll_req <= 4'h1;
    wait_rep(4'h1);
    ll_req <= 4'h9;
    wait_rep(4'h9);
    ll_req <= 4'h1;
    wait_rep(4'h1);
    pfat <= 1'b1;
    @(posedge sys_clk);
    pfat <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk("fatal", {1'b1, 4'hA}, {fatal, report});
    report_and_stop();
  end
endmodule // tb_dla_adapter
bind dla_adapter dla_adapter_properties u_dla_adapter_properties (.sys_clk,
  .reset_n, .phy_fatal_err, .phy_rx_valid, .phy_rx_bytes, .adapter_tx_ready,
  .adapter_rx_valid, .adapter_rx_bytes, .adapter_recoverable_err,
  .adapter_halt_request, .adapter_in_low_power_one,
  .adapter_in_low_power_two,
  .adapter_correctable_err, .adapter_fatal_err, .adapter_time_mark,
  .adapter_time_mark_stream_id, .adapter_sudden_drop, .adapter_state_report,
  .adapter_width_report, .adapter_rate_code, .adapter_protocol_code);
